// [verilog/bcbn_pkg.sv]
package bcbn_pkg;
   localparam int PC_W = 21;
   localparam int ADDR_W = 12;
   localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
   localparam logic [7:0] OPC_BRANCH_NEG = 8'he6;
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] Q_LAST = 2'h3;
   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_FLUSH = 2'b01
   } exec_state_t;
endpackage : bcbn_pkg

// [verilog/decode_if.sv]
`timescale 1ns/1ps
interface decode_if;
   import bcbn_pkg::*;
   logic [15:0] instr;
   logic is_clear;
   logic is_branch;
   logic [2:0] bit_sel;
   logic access;
   logic [7:0] file;
   logic [7:0] offset;
   modport dec (input instr, output is_clear, is_branch, bit_sel, access, file, offset);
   modport use_side (output instr, input is_clear, is_branch, bit_sel, access, file, offset);
endinterface : decode_if

// [verilog/instr_decode.sv]
`timescale 1ns/1ps
module instr_decode
   import bcbn_pkg::*;
(
   decode_if.dec d
);
   assign d.is_clear = (d.instr[15:12] == OPC_BIT_CLEAR);
   assign d.is_branch = (d.instr[15:8] == OPC_BRANCH_NEG);
   assign d.bit_sel = d.instr[11:9];
   assign d.access = d.instr[8];
   assign d.file = d.instr[7:0];
   assign d.offset = d.instr[7:0];
endmodule : instr_decode

// [verilog/bit_clear_branch.sv]
`timescale 1ns/1ps
module bit_clear_branch
   import bcbn_pkg::*;
#(
   parameter int PCW = PC_W
)(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic neg_flag_i,
   input wire logic ext_set_i,
   input wire logic [3:0] bank_select_register_i,
   input wire logic [ADDR_W-1:0] index_base_i,
   input wire logic [7:0] rd_data_i,
   output logic [ADDR_W-1:0] rd_addr_o,
   output logic [ADDR_W-1:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic wr_en_o,
   output logic [PCW-1:0] pc_o,
   output logic flush_o,
   output logic busy_o,
   output logic status_we_o
);
   decode_if d();
   instr_decode u_dec (
      .d(d)
   );
   exec_state_t state_r, state_nxt;
   logic [PCW-1:0] pc_r, pc_nxt;
   logic [ADDR_W-1:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic wr_en_r;
   wire logic take_in;
   wire logic do_clear;
   wire logic do_branch;
   wire logic taken;
   wire logic indexed;
   wire logic [ADDR_W-1:0] eff_addr;
   wire logic [7:0] clear_mask;
   wire logic [PCW-1:0] pc_inc;
   wire logic [PCW-1:0] rel;
   assign d.instr = instr_i;
   assign take_in = instr_valid_i && (state_r == ST_EXEC);
   assign do_clear = take_in && d.is_clear;
   assign do_branch = take_in && d.is_branch;
   assign taken = do_branch && neg_flag_i;
   assign indexed = !d.access && ext_set_i && (d.file <= INDEXED_MAX);
   assign eff_addr = d.access ? {bank_select_register_i, d.file} :
      indexed ? ADDR_W'(index_base_i + {4'h0, d.file}) :
      (d.file[7] ? {4'hf, d.file} : {4'h0, d.file});
   assign clear_mask = ~(8'h01 << d.bit_sel);
   assign pc_inc = PCW'(pc_r + PC_STEP);
   assign rel = PCW'({{(PCW-8){d.offset[7]}}, d.offset} <<< 1);
   assign pc_nxt = !take_in ? pc_r : (taken ? PCW'(pc_inc + rel) : pc_inc);
   // Flush state follows every taken branch for one cycle
   always_comb begin
      case (state_r)
         ST_EXEC: begin
            state_nxt = taken ? ST_FLUSH : ST_EXEC;
         end
         ST_FLUSH: begin
            state_nxt = ST_EXEC;
         end
         default: begin
            state_nxt = ST_EXEC;
         end
      endcase
   end
   assign rd_addr_o = eff_addr;
   assign wr_addr_o = wr_addr_r;
   assign wr_data_o = wr_data_r;
   assign wr_en_o = wr_en_r;
   assign pc_o = pc_r;
   assign flush_o = (state_r == ST_FLUSH);
   assign busy_o = (state_r == ST_FLUSH);
   assign status_we_o = 1'b0;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= ST_EXEC;
         pc_r <= PCW'(PC_RESET);
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
      end
   end
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_en_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= REG_RESET;
      end else begin
         wr_en_r <= do_clear;
         if (do_clear) begin
            wr_addr_r <= eff_addr;
            wr_data_r <= rd_data_i & clear_mask;
         end
      end
   end
   // Checks
   property p_taken_flush;
      @(posedge mclk_i) disable iff (!rst_b_i)
      taken |=> flush_o ##1 !flush_o;
   endproperty
   a_taken_flush: assert property (p_taken_flush) else $error("no single flush");
   property p_target;
      @(posedge mclk_i) disable iff (!rst_b_i)
      taken |=> pc_r == PCW'($past(pc_r) + PC_STEP
         + {{(PCW-9){$past(d.offset[7])}}, $past(d.offset), 1'b0});
   endproperty
   a_target: assert property (p_target) else $error("bad branch target");
   property p_not_taken;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_branch && !neg_flag_i) |=> pc_r == PCW'($past(pc_r) + PC_STEP) && !flush_o;
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("bad fall through");
   property p_clear_bit;
      @(posedge mclk_i) disable iff (!rst_b_i)
      do_clear |=> wr_en_o && wr_data_o == ($past(rd_data_i) & ~(8'h01 << $past(d.bit_sel)));
   endproperty
   a_clear_bit: assert property (p_clear_bit) else $error("bit clear wrong");
   property p_bank;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_clear && d.access) |=> wr_addr_o == {$past(bank_select_register_i), $past(d.file)};
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");
   property p_indexed;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_clear && indexed) |=> wr_addr_o == ADDR_W'($past(index_base_i) + $past(d.file));
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");
   property p_no_redirect;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (take_in && !taken) |=> !flush_o;
   endproperty
   a_no_redirect: assert property (p_no_redirect) else $error("unexpected redirect");
   property p_decode;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (instr_valid_i && !flush_o && instr_i[15:8] == 8'he6 && neg_flag_i) |=> flush_o;
   endproperty
   a_decode: assert property (p_decode) else $error("decode wrong");
   property p_flush_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
      flush_o |=> $stable(pc_r);
   endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("pc moved in flush");
   property p_flush_single;
      @(posedge mclk_i) disable iff (!rst_b_i)
      flush_o |=> !flush_o;
   endproperty
   a_flush_single: assert property (p_flush_single) else $error("flush too long");
   property p_bit_zero;
      @(posedge mclk_i) disable iff (!rst_b_i)
      do_clear |=> (wr_data_o & (8'h01 << $past(d.bit_sel))) == 8'h00;
   endproperty
   a_bit_zero: assert property (p_bit_zero) else $error("selected bit not zero");
   property p_keep_bits;
      @(posedge mclk_i) disable iff (!rst_b_i)
      do_clear |=> (wr_data_o | (8'h01 << $past(d.bit_sel)))
         == ($past(rd_data_i) | (8'h01 << $past(d.bit_sel)));
   endproperty
   a_keep_bits: assert property (p_keep_bits) else $error("other bits changed");
   property p_one_write;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_clear ##1 !do_clear) |=> !wr_en_o;
   endproperty
   a_one_write: assert property (p_one_write) else $error("write too long");
   property p_clear_write;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (instr_valid_i && !flush_o && instr_i[15:12] == 4'h9) |=> wr_en_o;
   endproperty
   a_clear_write: assert property (p_clear_write) else $error("clear not decoded");
   property p_no_stray_write;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (instr_valid_i && !flush_o && instr_i[15:12] != 4'h9) |=> !wr_en_o;
   endproperty
   a_no_stray_write: assert property (p_no_stray_write) else $error("stray write");
   property p_ext_off;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_clear && !d.access && !ext_set_i)
         |=> wr_addr_o == {{4{$past(d.file[7])}}, $past(d.file)};
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("access bank address wrong");
   property p_above_max;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_clear && !d.access && d.file > INDEXED_MAX)
         |=> wr_addr_o == {{4{$past(d.file[7])}}, $past(d.file)};
   endproperty
   a_above_max: assert property (p_above_max) else $error("indexed above limit");
   property p_rd_bank;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (take_in && instr_i[8]) |-> rd_addr_o == {bank_select_register_i, instr_i[7:0]};
   endproperty
   a_rd_bank: assert property (p_rd_bank) else $error("read bank address wrong");
   property p_rd_indexed;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (take_in && !instr_i[8] && ext_set_i && instr_i[7:0] <= INDEXED_MAX)
         |-> rd_addr_o == ADDR_W'(index_base_i + instr_i[7:0]);
   endproperty
   a_rd_indexed: assert property (p_rd_indexed) else $error("read indexed wrong");
   property p_branch_quiet;
      @(posedge mclk_i) disable iff (!rst_b_i)
      do_branch |=> !wr_en_o;
   endproperty
   a_branch_quiet: assert property (p_branch_quiet) else $error("branch wrote");
   property p_fall_busy;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (do_branch && !neg_flag_i) |=> !busy_o;
   endproperty
   a_fall_busy: assert property (p_fall_busy) else $error("busy on fall through");
   property p_refused;
      @(posedge mclk_i) disable iff (!rst_b_i)
      flush_o |=> !wr_en_o;
   endproperty
   a_refused: assert property (p_refused) else $error("write during flush");
   property p_neg_redirect;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (take_in && d.is_branch && neg_flag_i) |=> busy_o;
   endproperty
   a_neg_redirect: assert property (p_neg_redirect) else $error("branch not taken");
   property p_offset_even;
      @(posedge mclk_i) disable iff (!rst_b_i)
      taken |=> pc_r[0] == $past(pc_r[0]);
   endproperty
   a_offset_even: assert property (p_offset_even) else $error("odd branch step");
   property p_seq_pc;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (take_in && !d.is_branch) |=> pc_r == PCW'($past(pc_r) + PC_STEP);
   endproperty
   a_seq_pc: assert property (p_seq_pc) else $error("pc step wrong");
endmodule : bit_clear_branch

// [testbench/bit_clear_branch_test.sv]
`timescale 1ns/1ps
module bit_clear_branch_test;
   import bcbn_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic neg_flag_i = 1'b0;
   logic ext_set_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic [3:0] bank_select_register_i = 4'h3;
   logic [ADDR_W-1:0] index_base_i = 12'h120;
   logic [7:0] rd_data_i = 8'hc7;
   logic [ADDR_W-1:0] rd_addr_o;
   logic [ADDR_W-1:0] wr_addr_o;
   logic [7:0] wr_data_o;
   logic wr_en_o, flush_o, busy_o, status_we_o;
   logic [PC_W-1:0] pc_o;
   logic [PC_W-1:0] exp_pc;
   int errors = 0;
   int compares = 0;
   always #25 mclk_i = ~mclk_i;
   bit_clear_branch #(.PCW(PC_W)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .neg_flag_i(neg_flag_i), .ext_set_i(ext_set_i),
      .bank_select_register_i(bank_select_register_i), .index_base_i(index_base_i),
      .rd_data_i(rd_data_i), .rd_addr_o(rd_addr_o), .wr_addr_o(wr_addr_o),
      .wr_data_o(wr_data_o), .wr_en_o(wr_en_o), .pc_o(pc_o), .flush_o(flush_o),
      .busy_o(busy_o), .status_we_o(status_we_o));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Offer one word at the falling edge, let combinational outputs settle
   task automatic issue(input logic [15:0] w);
      @(negedge mclk_i);
      instr_i = w;
      instr_valid_i = 1'b1;
      #1;
   endtask : issue
   // Let the taking edge pass and withdraw the word
   task automatic step();
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
   endtask : step
   task automatic clear_cases();
      issue({4'h9, 3'd7, 1'b1, 8'h45});
      check("rd_addr", 12'h345, rd_addr_o);
      step();
      exp_pc = exp_pc + PC_STEP;
      check("wr_en", 1, wr_en_o);
      check("wr_addr", 12'h345, wr_addr_o);
      check("wr_data", 8'h47, wr_data_o);
      check("pc", exp_pc, pc_o);
      check("status_we", 0, status_we_o);
      ext_set_i = 1'b1;
      issue({4'h9, 3'd0, 1'b0, 8'h5f});
      check("rd_addr", 12'h17f, rd_addr_o);
      step();
      exp_pc = exp_pc + PC_STEP;
      check("wr_data", 8'hc6, wr_data_o);
      check("wr_addr", 12'h17f, wr_addr_o);
      check("pc", exp_pc, pc_o);
      issue({4'h9, 3'd3, 1'b0, 8'h60});
      check("rd_addr", 12'h060, rd_addr_o);
      step();
      exp_pc = exp_pc + PC_STEP;
      check("wr_data", 8'hc7, wr_data_o);
      check("wr_addr", 12'h060, wr_addr_o);
      ext_set_i = 1'b0;
      issue({4'h9, 3'd6, 1'b0, 8'h5f});
      check("rd_addr", 12'h05f, rd_addr_o);
      step();
      exp_pc = exp_pc + PC_STEP;
      check("wr_data", 8'h87, wr_data_o);
      check("wr_addr", 12'h05f, wr_addr_o);
      issue({4'h9, 3'd1, 1'b0, 8'h80});
      check("rd_addr", 12'hf80, rd_addr_o);
      step();
      exp_pc = exp_pc + PC_STEP;
      check("wr_data", 8'hc5, wr_data_o);
      check("wr_addr", 12'hf80, wr_addr_o);
      check("pc", exp_pc, pc_o);
   endtask : clear_cases
   task automatic branch_cases();
      neg_flag_i = 1'b1;
      issue(16'he680);
      @(negedge mclk_i);
      instr_i = 16'h9f45;
      exp_pc = exp_pc + PC_STEP - 21'h000100;
      check("pc", exp_pc, pc_o);
      check("flush", 1, flush_o);
      check("busy", 1, busy_o);
      step();
      check("flush", 0, flush_o);
      check("wr_en", 0, wr_en_o);
      check("pc", exp_pc, pc_o);
      issue(16'he67f);
      step();
      exp_pc = exp_pc + PC_STEP + 21'h0000fe;
      check("pc", exp_pc, pc_o);
      step();
      neg_flag_i = 1'b0;
      issue(16'he67f);
      step();
      exp_pc = exp_pc + PC_STEP;
      check("pc", exp_pc, pc_o);
      check("flush", 0, flush_o);
      check("status_we", 0, status_we_o);
   endtask : branch_cases
   // Reset cut into a flush cycle, then a branch from the reset address
   task automatic reset_case();
      neg_flag_i = 1'b1;
      issue(16'he601);
      @(negedge mclk_i);
      check("flush", 1, flush_o);
      rst_b_i = 1'b0;
      instr_valid_i = 1'b0;
      #1;
      check("flush", 0, flush_o);
      repeat (2) @(negedge mclk_i);
      rst_b_i = 1'b1;
      issue(16'he601);
      step();
      check("pc", 21'h000004, pc_o);
      check("flush", 1, flush_o);
   endtask : reset_case
   task automatic complete_run();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (2000) @(posedge mclk_i);
      errors++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_b_i = 1'b1;
      exp_pc = PC_RESET;
      check("pc", exp_pc, pc_o);
      clear_cases();
      branch_cases();
      reset_case();
      complete_run();
   end
endmodule : bit_clear_branch_test
